// File: hdl/dmac_pkg.sv
// Constants and types for the display memory access controller.
// Assumes one 125 MHz clock; processor bus and line address pins reach the core through three-flop sync.
// Functional notes
// - Strobe selector answers only I/O ports 52h to 55h, read and write.
// - Dual one-of-four decoder enabled by port range, bits 0-1 pick strobe.
// - Separate attribute and memory-map read and write strobes are produced.
// - Latch strobe loads data bits 0-2 and 7 into control outputs.
// - Data direction and gating follow memory read, request and attribute strobes.
// - Processor write cycles produce early write pulses to video and attribute memory.
// - Select and processor-access qualifiers come from request, refresh, region, timing clock.
// - While selected, processor address bits 1 to 10 drive memory address.
// - Video write data direct from processor; attribute data via buffer and mux.
// - Memory data paths are two-way so processor writes and reads back.
// - Refresh addresses all four blocks at once from line address bits 1-10.
// - Line address bit 0 picks output block, held while processor accesses.
// - Simple attribute option: black background, enable, flash, underline inactive.
package dmac_pkg;

  // I/O port map
  localparam logic [7:0] DMAC_PORT_ATTR   = 8'h52;
  localparam logic [7:0] DMAC_PORT_MEMMAP = 8'h53;
  localparam logic [7:0] DMAC_PORT_LATCH  = 8'h54;
  localparam logic [7:0] DMAC_PORT_STATUS = 8'h55;
  localparam logic [5:0] DMAC_GRP_LO      = 6'h14;
  localparam logic [5:0] DMAC_GRP_HI      = 6'h15;

  // Strobe indices inside the one-of-four group
  localparam int DMAC_IDX_ATTR   = 0;
  localparam int DMAC_IDX_MEMMAP = 1;
  localparam int DMAC_IDX_LATCH  = 2;
  localparam int DMAC_IDX_STATUS = 3;

  // Control latch fields and attribute port enable bit
  localparam int DMAC_BIT_TEXT_OFF = 0;
  localparam int DMAC_BIT_COLSEL = 1;
  localparam int DMAC_BIT_CTL2   = 2;
  localparam int DMAC_BIT_GFX    = 7;
  localparam int DMAC_BIT_ATTREN = 0;

  // Processor address fields
  localparam int DMAC_ABIT_BLOCK = 0;
  localparam int DMAC_ABIT_ATTR  = 11;

  // Reset values
  localparam logic [3:0] DMAC_CTL_RST    = 4'h0;
  localparam logic [7:0] DMAC_MEMMAP_RST = 8'h00;

  // Early write pulse timing
  localparam int DMAC_CLK_PS        = 8000;
  localparam int DMAC_WR_PULSE_NS   = 16;
  localparam int DMAC_WR_PULSE_CYC  = (DMAC_WR_PULSE_NS * 1000 + DMAC_CLK_PS - 1) / DMAC_CLK_PS;
  localparam int DMAC_WR_CNT_W      = 3;

  // Synchronised pin bundle
  typedef struct packed {
    logic [10:0] line_addr;
    logic [7:0]  cpu_data;
    logic [11:0] cpu_addr;
    logic        mem_read_n;
    logic        timing_clk;
    logic        region_n;
    logic        refresh_n;
    logic        mem_req;
  } dmac_pins_t;

endpackage

// File: hdl/dmac_strobe_if.sv
// Strobe bundle between the port decoder and the controller core.
// Assumes both ends share sys_clk_i; strobes are combinational, active low.
`timescale 1ns/1ps
interface dmac_strobe_if;
  logic [3:0] rd_n;
  logic [3:0] wr_n;
  modport dec (output rd_n, output wr_n);
  modport use_side (input rd_n, input wr_n);
endinterface

// File: hdl/dmac_pin_sync.sv
// Three-flop pin synchroniser with agreement filter.
// Assumes asynchronous inputs; output follows once stages two and three agree.
`timescale 1ns/1ps
module dmac_pin_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  // Pins
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] sync_o
);
  import dmac_pkg::*;

  if (W < 1) begin : g_chk
    $error("dmac_pin_sync: W must be at least 1");
  end

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } dmac_sync_t;

  dmac_sync_t st_reg;
  dmac_sync_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = pin_i;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.q  = (st_reg.s2 & ~(st_reg.s2 ^ st_reg.s3)) | (st_reg.q & (st_reg.s2 ^ st_reg.s3));
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_o = st_reg.q;
endmodule

// File: hdl/dmac_strobe_dec.sv
// Dual one-of-four I/O strobe selector for ports 52h to 55h.
// Assumes io read and write strobes come from the same clock domain.
`timescale 1ns/1ps
module dmac_strobe_dec (
  // Processor I/O cycle
  input  wire logic [7:0] io_addr_i,
  input  wire logic       io_read_i,
  input  wire logic       io_write_i,
  // Strobes
  dmac_strobe_if.dec      sif
);
  import dmac_pkg::*;

  // Active-low one-of-four pick
  function automatic logic [3:0] pick4(input logic en, input logic [1:0] idx);
    logic [3:0] r;
    r = 4'hF;
    if (en) begin
      r[idx] = 1'b0;
    end
    return r;
  endfunction

  logic       in_range;
  logic [1:0] idx;

  // Upper lines and bit 1 enable the selector for the four ports only
  assign in_range = ((io_addr_i[7:2] == DMAC_GRP_LO) && io_addr_i[1])
                 || ((io_addr_i[7:2] == DMAC_GRP_HI) && !io_addr_i[1]);
  // Low two lines choose the strobe
  assign idx      = io_addr_i[1:0] ^ 2'h2;
  assign sif.rd_n = pick4(in_range && io_read_i, idx);
  assign sif.wr_n = pick4(in_range && io_write_i, idx);
endmodule

// File: hdl/dmac_top.sv
// Display text and attribute memory access controller.
// Assumes pins from processor, display controller and memories are asynchronous;
// io strobes and register port are on sys_clk_i; memories are external SRAM.
`timescale 1ns/1ps
module dmac_top (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  // Register port (I/O cycles)
  input  wire logic [7:0]   io_addr_i,
  input  wire logic [7:0]   io_wdata_i,
  input  wire logic         io_write_i,
  input  wire logic         io_read_i,
  output logic      [7:0]   io_rdata_o,
  // Processor memory bus pins
  input  wire logic         buffered_mem_request_i,
  input  wire logic         buffered_refresh_n_i,
  input  wire logic         video_region_select_n_i,
  input  wire logic         access_timing_clock_i,
  input  wire logic         mem_read_n_i,
  input  wire logic [11:0]  cpu_addr_i,
  input  wire logic [7:0]   cpu_data_i,
  output logic      [7:0]   cpu_data_o,
  output logic              cpu_data_oe_o,
  // Display controller
  input  wire logic [10:0]  line_addr_i,
  // Memory blocks
  output logic      [9:0]   ram_addr_o,
  output logic      [7:0]   video_data_o,
  input  wire logic [15:0]  video_rdata_i,
  output logic      [1:0]   video_wr_n_o,
  output logic      [1:0]   attr_wr_n_o,
  input  wire logic [15:0]  attr_data_bus_i,
  output logic      [7:0]   attr_data_bus_o,
  output logic              attr_data_bus_oe_o,
  // Display data
  output logic      [7:0]   outgoing_text_data_o,
  output logic      [7:0]   outgoing_attr_data_o,
  // I/O strobes
  output logic              attr_read_strobe_n_o,
  output logic              attr_write_strobe_n_o,
  output logic              memmap_read_strobe_n_o,
  output logic              memmap_write_strobe_n_o,
  output logic              latch_in_strobe_n_o,
  output logic              latch_out_strobe_n_o,
  // Control latch
  output logic              text_off_o,
  output logic              colour_select_o,
  output logic              ctl_bit2_o,
  output logic              graphics_enable_ctl_o,
  // Simple attribute option
  output logic      [2:0]   bg_colour_o,
  output logic              attr_enable_ctl_o,
  output logic              flash_attr_o,
  output logic              underline_attr_o
);
  import dmac_pkg::*;

  typedef struct packed {
    logic                     tclk_d;
    logic                     sel;
    logic [DMAC_WR_CNT_W-1:0] wr_cnt;
    logic                     wr_blk;
    logic                     wr_attr;
    logic [1:0]               video_wr_n;
    logic [1:0]               attr_wr_n;
    logic [9:0]               ram_addr;
    logic [7:0]               video_data;
    logic [7:0]               attr_wbuf;
    logic [7:0]               cpu_rdata;
    logic                     cpu_oe;
    logic                     attr_oe;
    logic                     blk_sel;
    logic [7:0]               text_out;
    logic [7:0]               attr_out;
    logic [5:0]               strb_n;
    logic [3:0]               ctl;
    logic                     attr_path_en;
    logic [7:0]               memmap;
    logic [7:0]               io_rdata;
  } dmac_state_t;

  dmac_state_t  st_reg;
  dmac_state_t  st_next;
  dmac_pins_t   p;
  logic [$bits(dmac_pins_t)-1:0] p_raw;
  logic         tclk_rise;
  logic         qual;
  logic         start;
  logic         rd_cyc;
  logic         is_attr;

  dmac_strobe_if sif ();

  dmac_pin_sync #(
    .W ($bits(dmac_pins_t))
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .pin_i     ({line_addr_i, cpu_data_i, cpu_addr_i, mem_read_n_i, access_timing_clock_i,
                 video_region_select_n_i, buffered_refresh_n_i, buffered_mem_request_i}),
    .sync_o    (p_raw)
  );

  assign p = dmac_pins_t'(p_raw);

  dmac_strobe_dec u_dec (
    .io_addr_i  (io_addr_i),
    .io_read_i  (io_read_i),
    .io_write_i (io_write_i),
    .sif        (sif.dec)
  );

  assign tclk_rise = p.timing_clk && !st_reg.tclk_d;
  assign qual      = p.mem_req && p.refresh_n && !p.region_n;
  assign is_attr   = p.cpu_addr[DMAC_ABIT_ATTR];

  always_comb begin
    st_next        = st_reg;
    st_next.tclk_d = p.timing_clk;
    // Access qualifier opens on the timing clock edge, drops with the request
    st_next.sel    = qual && (st_reg.sel || tclk_rise);
    start          = st_next.sel && !st_reg.sel;
    rd_cyc         = st_next.sel && !p.mem_read_n;

    // Early write pulse, armed at the start of a write access
    if (start && p.mem_read_n) begin
      st_next.wr_cnt  = DMAC_WR_CNT_W'(DMAC_WR_PULSE_CYC);
      st_next.wr_blk  = p.cpu_addr[DMAC_ABIT_BLOCK];
      st_next.wr_attr = is_attr;
    end else if (st_reg.wr_cnt != '0) begin
      st_next.wr_cnt = st_reg.wr_cnt - 1'b1;
    end
    st_next.video_wr_n = 2'h3;
    st_next.attr_wr_n  = 2'h3;
    // Pulse trails the address by one cycle for address setup
    if (st_reg.wr_cnt != '0) begin
      if (!st_reg.wr_attr) begin
        st_next.video_wr_n[st_reg.wr_blk] = 1'b0;
      end else if (st_reg.attr_path_en) begin
        st_next.attr_wr_n[st_reg.wr_blk] = 1'b0;
      end
    end

    // Address multiplexer
    st_next.ram_addr = st_next.sel ? p.cpu_addr[10:1] : p.line_addr[10:1];

    // Write data paths: video direct, attribute via buffer
    st_next.video_data = p.cpu_data;
    if (start) begin
      st_next.attr_wbuf = p.cpu_data;
    end
    st_next.attr_oe = st_next.sel && p.mem_read_n && is_attr && st_reg.attr_path_en;

    // Read back to the processor
    st_next.cpu_oe = rd_cyc && (!is_attr || st_reg.attr_path_en);
    if (is_attr) begin
      st_next.cpu_rdata = p.cpu_addr[DMAC_ABIT_BLOCK] ? attr_data_bus_i[15:8] : attr_data_bus_i[7:0];
    end else begin
      st_next.cpu_rdata = p.cpu_addr[DMAC_ABIT_BLOCK] ? video_rdata_i[15:8] : video_rdata_i[7:0];
    end

    // Refresh output block choice, frozen during processor access
    if (!st_next.sel) begin
      st_next.blk_sel = p.line_addr[0];
    end
    if (!st_reg.sel) begin
      st_next.text_out = st_reg.blk_sel ? video_rdata_i[15:8] : video_rdata_i[7:0];
      st_next.attr_out = st_reg.blk_sel ? attr_data_bus_i[15:8] : attr_data_bus_i[7:0];
    end

    // Port strobes
    st_next.strb_n = {sif.wr_n[DMAC_IDX_LATCH], sif.rd_n[DMAC_IDX_LATCH],
                      sif.wr_n[DMAC_IDX_MEMMAP], sif.rd_n[DMAC_IDX_MEMMAP],
                      sif.wr_n[DMAC_IDX_ATTR], sif.rd_n[DMAC_IDX_ATTR]};

    // Port writes
    if (!sif.wr_n[DMAC_IDX_LATCH]) begin
      st_next.ctl = {io_wdata_i[DMAC_BIT_GFX], io_wdata_i[DMAC_BIT_CTL2],
                     io_wdata_i[DMAC_BIT_COLSEL], io_wdata_i[DMAC_BIT_TEXT_OFF]};
    end
    if (!sif.wr_n[DMAC_IDX_ATTR]) begin
      st_next.attr_path_en = io_wdata_i[DMAC_BIT_ATTREN];
    end
    if (!sif.wr_n[DMAC_IDX_MEMMAP]) begin
      st_next.memmap = io_wdata_i;
    end

    // Port reads, data valid in the following cycle only
    st_next.io_rdata = 8'h00;
    if (!sif.rd_n[DMAC_IDX_ATTR]) begin
      st_next.io_rdata = {7'h00, st_reg.attr_path_en};
    end else if (!sif.rd_n[DMAC_IDX_MEMMAP]) begin
      st_next.io_rdata = st_reg.memmap;
    end else if (!sif.rd_n[DMAC_IDX_LATCH]) begin
      st_next.io_rdata = {st_reg.ctl[3], 4'h0, st_reg.ctl[2:0]};
    end else if (!sif.rd_n[DMAC_IDX_STATUS]) begin
      st_next.io_rdata = {4'h0, (st_reg.wr_cnt != '0), st_reg.blk_sel, st_reg.sel, st_reg.attr_path_en};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_reg            <= '0;
      st_reg.video_wr_n <= 2'h3;
      st_reg.attr_wr_n  <= 2'h3;
      st_reg.strb_n     <= 6'h3F;
      st_reg.ctl        <= DMAC_CTL_RST;
      st_reg.memmap     <= DMAC_MEMMAP_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign io_rdata_o              = st_reg.io_rdata;
  assign cpu_data_o              = st_reg.cpu_rdata;
  assign cpu_data_oe_o           = st_reg.cpu_oe;
  assign ram_addr_o              = st_reg.ram_addr;
  assign video_data_o            = st_reg.video_data;
  assign video_wr_n_o            = st_reg.video_wr_n;
  assign attr_wr_n_o             = st_reg.attr_wr_n;
  assign attr_data_bus_o         = st_reg.attr_wbuf;
  assign attr_data_bus_oe_o      = st_reg.attr_oe;
  assign outgoing_text_data_o    = st_reg.text_out;
  assign outgoing_attr_data_o    = st_reg.attr_out;
  assign attr_read_strobe_n_o    = st_reg.strb_n[0];
  assign attr_write_strobe_n_o   = st_reg.strb_n[1];
  assign memmap_read_strobe_n_o  = st_reg.strb_n[2];
  assign memmap_write_strobe_n_o = st_reg.strb_n[3];
  assign latch_in_strobe_n_o     = st_reg.strb_n[4];
  assign latch_out_strobe_n_o    = st_reg.strb_n[5];
  assign text_off_o              = st_reg.ctl[0];
  assign colour_select_o         = st_reg.ctl[1];
  assign ctl_bit2_o              = st_reg.ctl[2];
  assign graphics_enable_ctl_o   = st_reg.ctl[3];
  // Simple attribute option: constant black background and idle attributes
  assign bg_colour_o             = 3'h0;
  assign attr_enable_ctl_o       = 1'b0;
  assign flash_attr_o            = 1'b0;
  assign underline_attr_o        = 1'b0;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_wr_start;
    !st_reg.sel ##1 (st_reg.sel && p.mem_read_n && !p.cpu_addr[DMAC_ABIT_ATTR]);
  endsequence
  sequence s_wr_pulse;
    (video_wr_n_o != 2'h3) [*2] ##1 (video_wr_n_o == 2'h3);
  endsequence

  property p_port_range;
    ((io_write_i || io_read_i) && ((io_addr_i < 8'h52) || (io_addr_i > 8'h55))) |=> (&st_reg.strb_n);
  endproperty
  a_port_range: assert property (p_port_range) else $error("strobe outside port range");

  property p_attr_wr_strobe;
    (io_write_i && io_addr_i == 8'h52) |=> !attr_write_strobe_n_o && attr_read_strobe_n_o;
  endproperty
  a_attr_wr_strobe: assert property (p_attr_wr_strobe) else $error("attribute write strobe missing");

  property p_mm_rd_strobe;
    (io_read_i && io_addr_i == 8'h53) |=> !memmap_read_strobe_n_o
      ##1 (memmap_read_strobe_n_o || ($past(io_read_i) && ($past(io_addr_i) == 8'h53)));
  endproperty
  a_mm_rd_strobe: assert property (p_mm_rd_strobe) else $error("memory map read strobe wrong");

  property p_latch_load;
    (io_write_i && io_addr_i == 8'h54) |=> (text_off_o == $past(io_wdata_i[0]))
      && (graphics_enable_ctl_o == $past(io_wdata_i[7])) && (ctl_bit2_o == $past(io_wdata_i[2]));
  endproperty
  a_latch_load: assert property (p_latch_load) else $error("control latch not loaded");

  property p_cpu_addr;
    st_reg.sel |-> ram_addr_o == $past(p.cpu_addr[10:1]);
  endproperty
  a_cpu_addr: assert property (p_cpu_addr) else $error("processor address not routed");

  property p_refresh_addr;
    !st_reg.sel |-> ram_addr_o == $past(p.line_addr[10:1]);
  endproperty
  a_refresh_addr: assert property (p_refresh_addr) else $error("refresh address not routed");

  property p_early_write;
    s_wr_start |=> s_wr_pulse;
  endproperty
  a_early_write: assert property (p_early_write) else $error("early write pulse wrong");

  property p_hold_blk;
    (st_reg.sel && $past(st_reg.sel)) |-> $stable(outgoing_text_data_o) && $stable(st_reg.blk_sel);
  endproperty
  a_hold_blk: assert property (p_hold_blk) else $error("block choice moved during access");

  property p_cpu_oe;
    cpu_data_oe_o |-> st_reg.sel && !$past(p.mem_read_n);
  endproperty
  a_cpu_oe: assert property (p_cpu_oe) else $error("data driven outside read access");

  property p_attr_opt;
    (bg_colour_o == 3'h0) && !attr_enable_ctl_o && !flash_attr_o && !underline_attr_o;
  endproperty
  a_attr_opt: assert property (p_attr_opt) else $error("simple attribute outputs active");

endmodule

// File: verif/dmac_mem_model.sv
// Behavioural model of the two video and two attribute memory blocks.
// Assumes the controller drives one address to all blocks and active-low write pulses.
`timescale 1ns/1ps
module dmac_mem_model (
  // Clock
  input  wire logic        sys_clk_i,
  // Controller memory side
  input  wire logic [9:0]  ram_addr_i,
  input  wire logic [7:0]  video_data_i,
  input  wire logic [7:0]  attr_data_i,
  input  wire logic        attr_oe_i,
  input  wire logic [1:0]  video_wr_n_i,
  input  wire logic [1:0]  attr_wr_n_i,
  // Read data
  output logic      [15:0] video_rdata_o,
  output logic      [15:0] attr_rdata_o
);
  // Blocks 0 and 1 video, 2 and 3 attribute
  logic [7:0] mem [4][1024];

  initial begin
    foreach (mem[b, a]) mem[b][a] = 8'h00;
  end

  // Undriven attribute bus stores garbage
  always @(posedge sys_clk_i) begin
    for (int b = 0; b < 2; b++) begin
      if (video_wr_n_i[b] === 1'b0) mem[b][ram_addr_i] <= video_data_i;
      if (attr_wr_n_i[b] === 1'b0) mem[b+2][ram_addr_i] <= attr_oe_i ? attr_data_i : ~mem[b+2][ram_addr_i];
    end
  end

  assign video_rdata_o = {mem[1][ram_addr_i], mem[0][ram_addr_i]};
  // Wire level: controller wins while it drives
  assign attr_rdata_o  = attr_oe_i ? {attr_data_i, attr_data_i} : {mem[3][ram_addr_i], mem[2][ram_addr_i]};
endmodule

// File: verif/test_display_memory_access_ctrl.sv
// Self-checking bench for the display memory access controller.
// Assumes dmac_mem_model stands in for the memory blocks; no random stimulus.
`timescale 1ns/1ps
`define CHK(what, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      n_fail++; \
      $display("Error %s expected %h seen %h", what, exp, got); \
    end \
  end
module test_display_memory_access_ctrl;
  import dmac_pkg::*;
  logic        sys_clk_i, rst_n_i, io_write_i, io_read_i;
  logic [7:0]  io_addr_i, io_wdata_i, io_rdata_o, cpu_data_i, cpu_data_o, video_data_o;
  logic [7:0]  attr_data_bus_o, outgoing_text_data_o, outgoing_attr_data_o;
  logic        buffered_mem_request_i, buffered_refresh_n_i, video_region_select_n_i;
  logic        access_timing_clock_i, mem_read_n_i, cpu_data_oe_o, attr_data_bus_oe_o;
  logic [11:0] cpu_addr_i;
  logic [10:0] line_addr_i;
  logic [9:0]  ram_addr_o, addr_seen;
  logic [15:0] video_rdata_i, attr_data_bus_i;
  logic [1:0]  video_wr_n_o, attr_wr_n_o;
  logic        attr_read_strobe_n_o, attr_write_strobe_n_o, memmap_read_strobe_n_o;
  logic        memmap_write_strobe_n_o, latch_in_strobe_n_o, latch_out_strobe_n_o;
  logic        text_off_o, colour_select_o, ctl_bit2_o, graphics_enable_ctl_o;
  logic [2:0]  bg_colour_o;
  logic        attr_enable_ctl_o, flash_attr_o, underline_attr_o, oe_seen;
  int          n_fail, compares, vlow[2], alow[2];
  logic [5:0]  stb;
  logic [7:0]  rdat, cpu_rd, attr_wd;

  dmac_top uut (
    .sys_clk_i, .rst_n_i, .io_addr_i, .io_wdata_i, .io_write_i, .io_read_i, .io_rdata_o,
    .buffered_mem_request_i, .buffered_refresh_n_i, .video_region_select_n_i, .access_timing_clock_i,
    .mem_read_n_i, .cpu_addr_i, .cpu_data_i, .cpu_data_o, .cpu_data_oe_o, .line_addr_i, .ram_addr_o,
    .video_data_o, .video_rdata_i, .video_wr_n_o, .attr_wr_n_o, .attr_data_bus_i, .attr_data_bus_o,
    .attr_data_bus_oe_o, .outgoing_text_data_o, .outgoing_attr_data_o, .attr_read_strobe_n_o,
    .attr_write_strobe_n_o, .memmap_read_strobe_n_o, .memmap_write_strobe_n_o, .latch_in_strobe_n_o,
    .latch_out_strobe_n_o, .text_off_o, .colour_select_o, .ctl_bit2_o, .graphics_enable_ctl_o,
    .bg_colour_o, .attr_enable_ctl_o, .flash_attr_o, .underline_attr_o
  );

  dmac_mem_model mem (
    .sys_clk_i(sys_clk_i), .ram_addr_i(ram_addr_o), .video_data_i(video_data_o),
    .attr_data_i(attr_data_bus_o), .attr_oe_i(attr_data_bus_oe_o), .video_wr_n_i(video_wr_n_o),
    .attr_wr_n_i(attr_wr_n_o), .video_rdata_o(video_rdata_i), .attr_rdata_o(attr_data_bus_i)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One I/O cycle; strobes and read data sampled in the answer cycle
  task automatic bus(input logic rd, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    io_read_i  <= rd;
    io_write_i <= !rd;
    io_addr_i  <= a;
    io_wdata_i <= d;
    @(posedge sys_clk_i);
    io_read_i  <= 1'b0;
    io_write_i <= 1'b0;
    #1;
    stb  = {attr_read_strobe_n_o, attr_write_strobe_n_o, memmap_read_strobe_n_o,
            memmap_write_strobe_n_o, latch_in_strobe_n_o, latch_out_strobe_n_o};
    rdat = io_rdata_o;
  endtask

  // One processor memory access window, recording what the controller did
  task automatic mem_cycle(input logic rd, input logic ref_n, input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    cpu_addr_i             <= a;
    cpu_data_i             <= d;
    mem_read_n_i           <= !rd;
    buffered_refresh_n_i   <= ref_n;
    buffered_mem_request_i <= 1'b1;
    @(posedge sys_clk_i);
    access_timing_clock_i  <= 1'b1;
    vlow    = '{0, 0};
    alow    = '{0, 0};
    oe_seen = 1'b0;
    attr_wd = 8'h00;
    for (int c = 0; c < 16; c++) begin
      @(posedge sys_clk_i);
      #1;
      for (int b = 0; b < 2; b++) begin
        vlow[b] += (video_wr_n_o[b] === 1'b0);
        alow[b] += (attr_wr_n_o[b] === 1'b0);
      end
      if (cpu_data_oe_o === 1'b1) begin
        oe_seen = 1'b1;
        cpu_rd  = cpu_data_o;
      end
      if (attr_wr_n_o !== 2'b11) attr_wd = (attr_data_bus_oe_o === 1'b1) ? attr_data_bus_o : 8'hXX;
      if (video_wr_n_o !== 2'b11 || attr_wr_n_o !== 2'b11 || cpu_data_oe_o === 1'b1) addr_seen = ram_addr_o;
    end
    @(posedge sys_clk_i);
    buffered_mem_request_i <= 1'b0;
    access_timing_clock_i  <= 1'b0;
    buffered_refresh_n_i   <= 1'b1;
    repeat (10) @(posedge sys_clk_i);
  endtask

  task automatic test_strobes();
    logic [7:0] ports [7] = '{8'h52, 8'h53, 8'h54, 8'h55, 8'h51, 8'h56, 8'hD3};
    logic [5:0] exp;
    for (int i = 0; i < 7; i++) begin
      for (int rd = 0; rd < 2; rd++) begin
        exp = 6'h3F;
        if (i < 3) exp[5 - 2 * i - (rd ? 0 : 1)] = 1'b0;
        bus(rd[0], ports[i], 8'h00);
        `CHK("strobes", exp, stb)
        if (rd && i > 3) `CHK("unmapped read", 8'h00, rdat)
      end
    end
    bus(0, 8'h53, 8'hA5);
    bus(1, 8'h53, 8'h00);
    `CHK("memmap read", 8'hA5, rdat)
    $display("test_strobes done");
  endtask

  task automatic test_latch();
    bus(0, 8'h54, 8'h81);
    `CHK("latch", 4'b1001, {graphics_enable_ctl_o, ctl_bit2_o, colour_select_o, text_off_o})
    bus(0, 8'h54, 8'h7E);
    `CHK("latch", 4'b0110, {graphics_enable_ctl_o, ctl_bit2_o, colour_select_o, text_off_o})
    bus(1, 8'h54, 8'h00);
    `CHK("latch read", 8'h06, rdat)
    $display("test_latch done");
  endtask

  task automatic test_memory();
    mem_cycle(0, 1, 12'h0A4, 8'h3C);
    `CHK("video pulse", DMAC_WR_PULSE_CYC, vlow[0])
    `CHK("other block", 0, vlow[1])
    `CHK("write addr", 10'h052, addr_seen)
    `CHK("oe on write", 1'b0, oe_seen)
    mem_cycle(0, 1, 12'h0A5, 8'hC3);
    `CHK("video pulse", DMAC_WR_PULSE_CYC, vlow[1])
    mem_cycle(1, 1, 12'h0A5, 8'h00);
    `CHK("read oe", 1'b1, oe_seen)
    `CHK("video readback", 8'hC3, cpu_rd)
    mem_cycle(0, 1, 12'h8A5, 8'h66);
    `CHK("attr refused", 0, alow[1])
    bus(0, 8'h52, 8'h01);
    bus(1, 8'h52, 8'h00);
    `CHK("attr enable", 8'h01, rdat)
    mem_cycle(0, 1, 12'h8A5, 8'h66);
    `CHK("attr pulse", DMAC_WR_PULSE_CYC, alow[1])
    `CHK("attr data", 8'h66, attr_wd)
    mem_cycle(1, 1, 12'h8A5, 8'h00);
    `CHK("attr readback", 8'h66, cpu_rd)
    mem_cycle(0, 1, 12'h8A4, 8'h99);
    mem_cycle(0, 0, 12'h0A4, 8'h11);
    `CHK("refresh blocks", 0, vlow[0])
    video_region_select_n_i <= 1'b1;
    mem_cycle(0, 1, 12'h0A4, 8'h22);
    `CHK("region blocks", 0, vlow[0])
    video_region_select_n_i <= 1'b0;
    bus(1, 8'h55, 8'h00);
    `CHK("status", 8'h01, rdat)
    $display("test_memory done");
  endtask

  task automatic refresh_at(input logic [10:0] la, input logic [7:0] txt, input logic [7:0] att);
    @(posedge sys_clk_i);
    line_addr_i <= la;
    for (int c = 0; c < 14 && !(ram_addr_o === la[10:1] && outgoing_text_data_o === txt); c++) begin
      @(posedge sys_clk_i);
      #1;
    end
    `CHK("refresh addr", la[10:1], ram_addr_o)
    `CHK("text out", txt, outgoing_text_data_o)
    `CHK("attr out", att, outgoing_attr_data_o)
  endtask

  task automatic test_refresh();
    refresh_at(11'h0A5, 8'hC3, 8'h66);
    refresh_at(11'h0A4, 8'h3C, 8'h99);
    `CHK("simple option", 6'h00, {bg_colour_o, attr_enable_ctl_o, flash_attr_o, underline_attr_o})
    $display("test_refresh done");
  endtask

  initial begin
    #50us;
    n_fail++;
    test_done();
  end

  initial begin
    n_fail = 0;
    compares = 0;
    rst_n_i = 1'b0;
    {io_write_i, io_read_i, buffered_mem_request_i, access_timing_clock_i} = 4'h0;
    {buffered_refresh_n_i, mem_read_n_i, video_region_select_n_i} = 3'b110;
    io_addr_i = 8'h00;
    io_wdata_i = 8'h00;
    cpu_addr_i = 12'h000;
    cpu_data_i = 8'h00;
    line_addr_i = 11'h000;
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    #1;
    `CHK("idle strobes", 4'hF, {video_wr_n_o, attr_wr_n_o})
    test_strobes();
    test_latch();
    test_memory();
    test_refresh();
    test_done();
  end
endmodule
